// ==== cop_operand_prims.sv ====
`timescale 1ns/10ps
module cop_operand_prims
  import cop_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_prim_valid,
  input wire logic [15:0] i_prim_word,
  input wire logic i_cond_cat,
  input wire logic [2:0] i_ea_mode,
  input wire logic [2:0] i_ea_reg,
  input wire logic i_if_ack,
  input wire logic [15:0] i_if_data,
  input wire logic i_cir_ack,
  input wire logic [31:0] i_cir_rdata,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  input wire logic [31:0] i_reg_rdata,
  input wire logic [1:0] i_sw_addr,
  input wire logic [31:0] i_sw_wdata,
  input wire logic i_sw_wr,
  input wire logic i_sw_rd,
  output logic o_if_req,
  output logic [31:0] o_if_addr,
  output logic o_cir_wr,
  output logic o_cir_rd,
  output logic [1:0] o_cir_sel,
  output logic [2:0] o_cir_size,
  output logic [31:0] o_cir_wdata,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [31:0] o_mem_addr,
  output logic [2:0] o_mem_size,
  output logic [31:0] o_mem_wdata,
  output logic [3:0] o_reg_idx,
  output logic o_reg_wr,
  output logic [31:0] o_reg_wdata,
  output logic o_busy,
  output logic o_done,
  output logic o_come_again,
  output logic o_proto_viol,
  output logic o_opcode_emul,
  output logic [31:0] o_sw_rdata
);

  typedef struct packed {
    cop_state_t st;
    logic [15:0] prim;
    logic [2:0] mode;
    logic [2:0] rsel;
    logic [7:0] len;
    logic dr;
    logic [31:0] scan;
    logic [31:0] addr;
    logic [15:0] acc;
    logic half;
    logic phase;
    logic [1:0] need;
    logic abort;
    logic if_req;
    logic cir_wr;
    logic cir_rd;
    logic [1:0] cir_sel;
    logic [2:0] cir_size;
    logic [31:0] cir_wdata;
    logic mem_rd;
    logic mem_wr;
    logic [2:0] mem_size;
    logic [31:0] mem_wdata;
    logic [3:0] reg_idx;
    logic reg_wr;
    logic [31:0] reg_wdata;
    logic busy;
    logic done;
    logic pviol;
    logic femul;
    logic last_pv;
    logic last_fe;
    logic [31:0] rdata;
  } cop_regs_t;

  cop_regs_t s;
  cop_regs_t n;

  logic w_is;
  logic w_eaa;
  logic w_eat;
  logic eat;
  logic regd;
  logic imm;
  logic supp;
  logic ctl;
  logic alt;
  logic dat;
  logic mem;
  logic cat_ok;
  logic len_ok;
  logic [2:0] chunk;
  logic [31:0] step;
  logic [31:0] ext_sx;
  logic pend;
  logic addr_ready;

  // Primitive decode and mode classification; index modes are left to software emulation.
  always_comb begin
    w_is = (i_prim_word[13:8] == IS_CODE);
    w_eaa = (i_prim_word[13:8] == EAA_CODE) && (i_prim_word[7:0] == EAA_LOW);
    w_eat = (i_prim_word[12:11] == EAT_CODE);
    eat = (s.prim[12:11] == EAT_CODE);
    regd = (s.mode == MD_DREG) || (s.mode == MD_AREG);
    imm = (s.mode == MD_EXT) && (s.rsel == XR_IMM);
    supp = (s.mode <= MD_DISP) || ((s.mode == MD_EXT) && (s.rsel <= XR_PCD)) || imm;
    ctl = (s.mode == MD_IND) || (s.mode == MD_DISP) || ((s.mode == MD_EXT) && (s.rsel <= XR_PCD));
    alt = (s.mode != MD_EXT) || (s.rsel <= XR_ABSL);
    dat = (s.mode != MD_AREG);
    mem = !regd;
    // Category field picks the allowed class of the operation word's mode.
    case (s.prim[10:8])
      CAT_CTRL_ALT: cat_ok = ctl && alt;
      CAT_DATA_ALT: cat_ok = dat && alt;
      CAT_MEM_ALT: cat_ok = mem && alt;
      CAT_ALT: cat_ok = alt;
      CAT_CTRL: cat_ok = ctl;
      CAT_DATA: cat_ok = dat;
      CAT_MEM: cat_ok = mem;
      default: cat_ok = 1'b1;
    endcase
    len_ok = (s.len == LEN_BYTE) || (s.len == LEN_WORD) || (s.len == LEN_LONG);
    chunk = (s.len >= LEN_LONG) ? SZ_LONG : s.len[2:0];
    // The stack pointer stays word aligned for byte operands.
    if ((s.len == LEN_BYTE) && (s.rsel == SP_REG)) begin
      step = EXT_STEP;
    end else begin
      step = {24'h0, s.len};
    end
    ext_sx = {{16{i_if_data[15]}}, i_if_data};
    pend = s.mem_rd || s.mem_wr || s.cir_rd || s.cir_wr;
  end

  // Next-state logic: one sequence per primitive, handshakes held until acknowledged.
  always_comb begin
    n = s;
    addr_ready = 1'b0;
    n.done = 1'b0;
    n.pviol = 1'b0;
    n.femul = 1'b0;
    n.reg_wr = 1'b0;
    n.rdata = 32'h0;
    if (i_sw_rd && (i_sw_addr == SW_SCAN)) begin
      n.rdata = s.scan;
    end else if (i_sw_rd && (i_sw_addr == SW_STAT)) begin
      n.rdata = {29'h0, s.busy, s.last_fe, s.last_pv};
    end
    // Loading the scan pointer mid-sequence would corrupt the stream, so a write outside idle is dropped.
    if (i_sw_wr && (i_sw_addr == SW_SCAN) && (s.st == ST_IDLE)) begin
      n.scan = i_sw_wdata;
    end
    case (s.st)
      ST_IDLE: begin
        if (i_prim_valid) begin
          n.prim = i_prim_word;
          n.mode = i_ea_mode;
          n.rsel = i_ea_reg;
          n.len = i_prim_word[7:0];
          n.dr = i_prim_word[DIR_BIT];
          n.reg_idx = {i_ea_mode != MD_DREG, i_ea_reg};
          n.half = 1'b0;
          n.phase = 1'b0;
          if (w_is && i_cond_cat && !i_prim_word[CA_BIT]) begin
            n.pviol = 1'b1;
          end else if (w_is && i_prim_word[0]) begin
            n.pviol = 1'b1;
          end else if (w_is && (i_prim_word[7:0] == 8'h00)) begin
            n.done = 1'b1;
          end else if (w_is) begin
            n.st = ST_ISTR;
            n.if_req = 1'b1;
          end else if ((w_eaa || w_eat) && i_cond_cat) begin
            n.pviol = 1'b1;
          end else if (w_eaa || w_eat) begin
            n.st = ST_EAREG;
          end else begin
            n.pviol = 1'b1;
          end
        end
      end
      ST_EAREG: begin
        if (!supp || (!eat && !(ctl && alt)) || (eat && !cat_ok)) begin
          n.st = ST_ONEW;
          n.abort = 1'b1;
          n.cir_wr = 1'b1;
          n.cir_sel = SEL_CTRL;
          n.cir_size = SZ_WORD;
          n.cir_wdata = ABORT_MASK;
        end else if (eat && s.dr && !alt) begin
          n.pviol = 1'b1;
          n.st = ST_IDLE;
        end else if (eat && regd && !len_ok) begin
          n.pviol = 1'b1;
          n.st = ST_IDLE;
        end else if (imm && (s.dr || (s.len[0] && (s.len != LEN_BYTE)))) begin
          n.pviol = 1'b1;
          n.st = ST_IDLE;
        end else if (regd) begin
          n.st = ST_REGX;
        end else if (imm && (s.len == 8'h00)) begin
          n.done = 1'b1;
          n.st = ST_IDLE;
        end else if (imm) begin
          n.st = ST_ISTR;
          n.if_req = 1'b1;
        end else if (s.mode == MD_IND) begin
          n.addr = i_reg_rdata;
          addr_ready = 1'b1;
        end else if (s.mode == MD_POST) begin
          n.addr = i_reg_rdata;
          n.reg_wr = 1'b1;
          n.reg_wdata = i_reg_rdata + step;
          addr_ready = 1'b1;
        end else if (s.mode == MD_PRE) begin
          n.addr = i_reg_rdata - step;
          n.reg_wr = 1'b1;
          n.reg_wdata = i_reg_rdata - step;
          addr_ready = 1'b1;
        end else begin
          n.st = ST_EXT;
          n.if_req = 1'b1;
          n.need = ((s.mode == MD_EXT) && (s.rsel == XR_ABSL)) ? 2'h2 : 2'h1;
        end
      end
      ST_EXT: begin
        if (i_if_ack) begin
          n.scan = s.scan + EXT_STEP;
          n.acc = i_if_data;
          n.need = s.need - 2'h1;
          if (s.need == 2'h1) begin
            n.if_req = 1'b0;
            addr_ready = 1'b1;
            if (s.mode == MD_DISP) begin
              n.addr = i_reg_rdata + ext_sx;
            end else if (s.rsel == XR_ABSW) begin
              n.addr = ext_sx;
            end else if (s.rsel == XR_ABSL) begin
              n.addr = {s.acc, i_if_data};
            end else begin
              n.addr = s.scan + ext_sx;
            end
          end
        end
      end
      ST_ISTR: begin
        if (s.if_req && i_if_ack) begin
          n.scan = s.scan + EXT_STEP;
          n.acc = i_if_data;
          if (s.len == LEN_BYTE) begin
            n.if_req = 1'b0;
            n.cir_wr = 1'b1;
            n.cir_size = SZ_BYTE;
            n.cir_wdata = {24'h0, i_if_data[7:0]};
            n.len = 8'h00;
          end else if (!s.half && (s.len >= LEN_LONG)) begin
            n.half = 1'b1;
          end else begin
            n.if_req = 1'b0;
            n.cir_wr = 1'b1;
            n.half = 1'b0;
            n.cir_size = s.half ? SZ_LONG : SZ_WORD;
            n.cir_wdata = s.half ? {s.acc, i_if_data} : {16'h0, i_if_data};
            n.len = s.len - (s.half ? LEN_LONG : LEN_WORD);
          end
          n.cir_sel = SEL_OPER;
        end else if (s.cir_wr && i_cir_ack) begin
          n.cir_wr = 1'b0;
          if (s.len == 8'h00) begin
            n.done = 1'b1;
            n.st = ST_IDLE;
          end else begin
            n.if_req = 1'b1;
          end
        end
      end
      ST_REGX: begin
        n.cir_sel = SEL_OPER;
        n.cir_size = s.len[2:0];
        if (!s.phase) begin
          n.phase = 1'b1;
          n.cir_wr = !s.dr;
          n.cir_rd = s.dr;
          n.cir_wdata = i_reg_rdata;
        end else if (i_cir_ack) begin
          n.cir_wr = 1'b0;
          n.cir_rd = 1'b0;
          n.reg_wr = s.dr;
          if (s.reg_idx[3] && (s.len == LEN_BYTE)) begin
            n.reg_wdata = {{24{i_cir_rdata[7]}}, i_cir_rdata[7:0]};
          end else if (s.reg_idx[3] && (s.len == LEN_WORD)) begin
            n.reg_wdata = {{16{i_cir_rdata[15]}}, i_cir_rdata[15:0]};
          end else if (s.len == LEN_BYTE) begin
            n.reg_wdata = {i_reg_rdata[31:8], i_cir_rdata[7:0]};
          end else if (s.len == LEN_WORD) begin
            n.reg_wdata = {i_reg_rdata[31:16], i_cir_rdata[15:0]};
          end else begin
            n.reg_wdata = i_cir_rdata;
          end
          n.done = 1'b1;
          n.st = ST_IDLE;
        end
      end
      ST_MEM: begin
        // Each part is read from its source, then written to its sink, ascending.
        n.cir_sel = SEL_OPER;
        if (!pend) begin
          n.cir_rd = s.dr;
          n.mem_rd = !s.dr;
          n.cir_size = chunk;
          n.mem_size = chunk;
        end else if (!s.phase && ((s.mem_rd && i_mem_ack) || (s.cir_rd && i_cir_ack))) begin
          n.mem_rd = 1'b0;
          n.cir_rd = 1'b0;
          n.phase = 1'b1;
          n.mem_wr = s.dr;
          n.cir_wr = !s.dr;
          n.mem_wdata = i_cir_rdata;
          n.cir_wdata = i_mem_rdata;
        end else if (s.phase && ((s.mem_wr && i_mem_ack) || (s.cir_wr && i_cir_ack))) begin
          n.mem_wr = 1'b0;
          n.cir_wr = 1'b0;
          n.phase = 1'b0;
          n.addr = s.addr + {29'h0, chunk};
          n.len = s.len - {5'h0, chunk};
          if (s.len == {5'h0, chunk}) begin
            n.done = 1'b1;
            n.st = ST_IDLE;
          end
        end
      end
      ST_ONEW: begin
        if (i_cir_ack) begin
          n.cir_wr = 1'b0;
          n.femul = s.abort;
          n.done = !s.abort;
          n.abort = 1'b0;
          n.st = ST_IDLE;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    // A finished address goes to the address register, ends a zero-length move, or starts the data move.
    if (addr_ready && !eat) begin
      n.st = ST_ONEW;
      n.cir_wr = 1'b1;
      n.cir_sel = SEL_ADDR;
      n.cir_size = SZ_LONG;
      n.cir_wdata = n.addr;
    end else if (addr_ready && (s.len == 8'h00)) begin
      n.done = 1'b1;
      n.st = ST_IDLE;
    end else if (addr_ready) begin
      n.st = ST_MEM;
      n.phase = 1'b0;
    end
    if (n.pviol || n.femul) begin
      n.last_pv = n.pviol;
      n.last_fe = n.femul;
    end
    n.busy = (n.st != ST_IDLE);
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
      s.st <= ST_IDLE;
    end else begin
      s <= n;
    end
  end

  assign o_if_req = s.if_req;
  assign o_if_addr = s.scan;
  assign o_cir_wr = s.cir_wr;
  assign o_cir_rd = s.cir_rd;
  assign o_cir_sel = s.cir_sel;
  assign o_cir_size = s.cir_size;
  assign o_cir_wdata = s.cir_wdata;
  assign o_mem_rd = s.mem_rd;
  assign o_mem_wr = s.mem_wr;
  assign o_mem_addr = s.addr;
  assign o_mem_size = s.mem_size;
  assign o_mem_wdata = s.mem_wdata;
  assign o_reg_idx = s.reg_idx;
  assign o_reg_wr = s.reg_wr;
  assign o_reg_wdata = s.reg_wdata;
  assign o_busy = s.busy;
  assign o_done = s.done;
  assign o_come_again = s.prim[CA_BIT];
  assign o_proto_viol = s.pviol;
  assign o_opcode_emul = s.femul;
  assign o_sw_rdata = s.rdata;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Guards on the primitive sequences.
  cond_stream_a: assert property ((s.st == ST_IDLE) && i_prim_valid && w_is && i_cond_cat && !i_prim_word[CA_BIT] |=> o_proto_viol && !o_busy) else $error("stream primitive in conditional not refused");
  odd_len_a: assert property ((s.st == ST_IDLE) && i_prim_valid && w_is && i_prim_word[0] |=> o_proto_viol) else $error("odd stream length not refused");
  cond_ea_a: assert property ((s.st == ST_IDLE) && i_prim_valid && (w_eaa || w_eat) && i_cond_cat |=> o_proto_viol ##1 !o_busy) else $error("address primitive in conditional not refused");
  scan_step_a: assert property (o_if_req && i_if_ack |=> o_if_addr == $past(o_if_addr) + EXT_STEP) else $error("scan pointer did not step by two");
  abort_val_a: assert property (o_cir_wr && (o_cir_sel == SEL_CTRL) && i_cir_ack |-> (o_cir_wdata == ABORT_MASK) ##1 o_opcode_emul) else $error("abort write wrong");
  stream_word_a: assert property ((s.st == ST_ISTR) && o_cir_wr && (o_cir_size == SZ_WORD) |-> (s.len == 8'h00)) else $error("word write not last");
  regdir_len_a: assert property ((s.st == ST_REGX) |-> len_ok) else $error("bad register direct length");
  imm_dir_a: assert property ((s.st == ST_ISTR) && eat |-> !s.dr) else $error("immediate toward processor");
  sign_ext_a: assert property (o_reg_wr && o_reg_idx[3] && (s.st == ST_IDLE) && (s.len == LEN_BYTE) |-> (o_reg_wdata[31:8] == {24{o_reg_wdata[7]}})) else $error("byte not sign-extended");
  mem_dir_a: assert property (o_mem_wr |-> s.dr) else $error("memory written against direction");
  alt_write_a: assert property ((s.st == ST_EAREG) && eat && cat_ok && supp && s.dr && !alt |=> o_proto_viol) else $error("write to non-alterable address");

  stream_done_c: cover property ((s.st == ST_ISTR) ##[1:40] o_done);
  addr_send_c: cover property (o_cir_wr && (o_cir_sel == SEL_ADDR) && i_cir_ack);
  mem_move_c: cover property ((s.st == ST_MEM) && o_mem_wr ##[1:40] o_done);

endmodule : cop_operand_prims

// ==== cop_pkg.sv ====
package cop_pkg;

  // Primitive word layout.
  localparam int CA_BIT = 15;
  localparam int DIR_BIT = 13;
  localparam logic [5:0] EAA_CODE = 6'h0a;
  localparam logic [7:0] EAA_LOW = 8'h00;
  localparam logic [5:0] IS_CODE = 6'h0f;
  localparam logic [1:0] EAT_CODE = 2'h2;

  // Address category codes of the evaluate-and-transfer-data primitive.
  localparam logic [2:0] CAT_CTRL_ALT = 3'h0;
  localparam logic [2:0] CAT_DATA_ALT = 3'h1;
  localparam logic [2:0] CAT_MEM_ALT = 3'h2;
  localparam logic [2:0] CAT_ALT = 3'h3;
  localparam logic [2:0] CAT_CTRL = 3'h4;
  localparam logic [2:0] CAT_DATA = 3'h5;
  localparam logic [2:0] CAT_MEM = 3'h6;
  localparam logic [2:0] CAT_ANY = 3'h7;

  // Addressing modes of the operation word and the mode-7 register codes.
  localparam logic [2:0] MD_DREG = 3'h0;
  localparam logic [2:0] MD_AREG = 3'h1;
  localparam logic [2:0] MD_IND = 3'h2;
  localparam logic [2:0] MD_POST = 3'h3;
  localparam logic [2:0] MD_PRE = 3'h4;
  localparam logic [2:0] MD_DISP = 3'h5;
  localparam logic [2:0] MD_EXT = 3'h7;
  localparam logic [2:0] XR_ABSW = 3'h0;
  localparam logic [2:0] XR_ABSL = 3'h1;
  localparam logic [2:0] XR_PCD = 3'h2;
  localparam logic [2:0] XR_IMM = 3'h4;
  localparam logic [2:0] SP_REG = 3'h7;

  // Coprocessor interface register selects, sizes and abort value.
  localparam logic [1:0] SEL_OPER = 2'h0;
  localparam logic [1:0] SEL_ADDR = 2'h1;
  localparam logic [1:0] SEL_CTRL = 2'h2;
  localparam logic [2:0] SZ_BYTE = 3'h1;
  localparam logic [2:0] SZ_WORD = 3'h2;
  localparam logic [2:0] SZ_LONG = 3'h4;
  localparam logic [7:0] LEN_BYTE = 8'h01;
  localparam logic [7:0] LEN_WORD = 8'h02;
  localparam logic [7:0] LEN_LONG = 8'h04;
  localparam logic [31:0] ABORT_MASK = 32'h0000_0001;
  localparam logic [31:0] EXT_STEP = 32'h0000_0002;

  // Software register map.
  localparam logic [1:0] SW_SCAN = 2'h0;
  localparam logic [1:0] SW_STAT = 2'h1;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_EAREG = 7'h02,
    ST_EXT = 7'h04,
    ST_ISTR = 7'h08,
    ST_MEM = 7'h10,
    ST_REGX = 7'h20,
    ST_ONEW = 7'h40
  } cop_state_t;

endpackage : cop_pkg

// ==== cop_far_model.sv ====
`timescale 1ns/10ps
// Far side of the primitive sequencer: instruction fetch, coprocessor registers and memory.
// Each channel answers a request after a programmable number of wait cycles, and answers again while it stays held.
module cop_far_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_dly,
  input wire logic [15:0] i_seed,
  input wire logic i_if_req,
  input wire logic [31:0] i_if_addr,
  input wire logic i_cir_req,
  input wire logic i_mem_req,
  input wire logic [31:0] i_mem_addr,
  output logic o_if_ack,
  output logic [15:0] o_if_data,
  output logic o_cir_ack,
  output logic [31:0] o_cir_rdata,
  output logic o_mem_ack,
  output logic [31:0] o_mem_rdata
);
  logic [2:0] req;
  logic [2:0] ack;
  logic [1:0] cnt [3];
  logic [15:0] if_val;
  logic [31:0] mem_val;

  // Channel order is fetch, coprocessor register, memory.
  assign req = {i_mem_req, i_cir_req, i_if_req};
  assign {o_mem_ack, o_cir_ack, o_if_ack} = ack;

  // The ack is a one-cycle pulse; the counter restarts so a request kept high counts as new.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack <= 3'h0;
      cnt <= '{2'h0, 2'h0, 2'h0};
    end else begin
      for (int k = 0; k < 3; k++) begin
        ack[k] <= 1'b0;
        if (req[k] && !ack[k]) begin
          if (cnt[k] >= i_dly) begin
            ack[k] <= 1'b1;
            cnt[k] <= 2'h0;
          end else begin
            cnt[k] <= cnt[k] + 2'h1;
          end
        end
      end
    end
  end

  // Data is only valid with the ack; otherwise the inverse shows so early sampling is caught.
  assign if_val = i_if_addr[15:0] ^ i_seed;
  assign mem_val = i_mem_addr ^ {i_seed, i_seed};
  assign o_if_data = o_if_ack ? if_val : ~if_val;
  assign o_mem_rdata = o_mem_ack ? mem_val : ~mem_val;
  assign o_cir_rdata = o_cir_ack ? {i_seed, ~i_seed} : {~i_seed, i_seed};
endmodule : cop_far_model

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
  import cop_pkg::*;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_prim_valid = 1'b0, i_cond_cat = 1'b0;
  logic i_sw_wr = 1'b0, i_sw_rd = 1'b0, rd_q = 1'b0;
  logic [15:0] i_prim_word = 16'h0, seed = 16'h0;
  logic [2:0] i_ea_mode = 3'h0, i_ea_reg = 3'h0;
  logic [1:0] i_sw_addr = 2'h0, dly = 2'h0;
  logic [31:0] i_sw_wdata = 32'h0, xs_st = 32'h0000_d008, base;
  logic i_if_ack, i_cir_ack, i_mem_ack, o_if_req, o_cir_wr, o_cir_rd, o_mem_rd, o_mem_wr;
  logic o_reg_wr, o_busy, o_done, o_come_again, o_proto_viol, o_opcode_emul;
  logic [15:0] i_if_data;
  logic [31:0] i_cir_rdata, i_mem_rdata, i_reg_rdata, o_if_addr, o_cir_wdata, o_mem_addr;
  logic [31:0] o_mem_wdata, o_reg_wdata, o_sw_rdata;
  logic [1:0] o_cir_sel;
  logic [2:0] o_cir_size, o_mem_size;
  logic [3:0] o_reg_idx;
  logic [39:0] exp_q [$];
  int n_fail = 0, compares = 0;

  // Clock of 100 ns period.
  always #50 i_clk = ~i_clk;

  // Register file answers with a seed-dependent value that also names the register.
  assign i_reg_rdata = {seed, 12'h010, o_reg_idx};

  cop_operand_prims u_cop_operand_prims (
    .i_clk, .i_rst_n, .i_prim_valid, .i_prim_word, .i_cond_cat, .i_ea_mode, .i_ea_reg,
    .i_if_ack, .i_if_data, .i_cir_ack, .i_cir_rdata, .i_mem_ack, .i_mem_rdata, .i_reg_rdata,
    .i_sw_addr, .i_sw_wdata, .i_sw_wr, .i_sw_rd, .o_if_req, .o_if_addr, .o_cir_wr, .o_cir_rd,
    .o_cir_sel, .o_cir_size, .o_cir_wdata, .o_mem_rd, .o_mem_wr, .o_mem_addr, .o_mem_size,
    .o_mem_wdata, .o_reg_idx, .o_reg_wr, .o_reg_wdata, .o_busy, .o_done, .o_come_again,
    .o_proto_viol, .o_opcode_emul, .o_sw_rdata);

  cop_far_model u_cop_far_model (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_dly(dly), .i_seed(seed), .i_if_req(o_if_req),
    .i_if_addr(o_if_addr), .i_cir_req(o_cir_wr | o_cir_rd), .i_mem_req(o_mem_rd | o_mem_wr),
    .i_mem_addr(o_mem_addr), .o_if_ack(i_if_ack), .o_if_data(i_if_data),
    .o_cir_ack(i_cir_ack), .o_cir_rdata(i_cir_rdata), .o_mem_ack(i_mem_ack),
    .o_mem_rdata(i_mem_rdata));

  function automatic logic [31:0] xs();
    xs_st = xs_st ^ (xs_st << 13);
    xs_st = xs_st ^ (xs_st >> 17);
    xs_st = xs_st ^ (xs_st << 5);
    return xs_st;
  endfunction : xs

  function automatic logic [31:0] reg_val(input logic [3:0] idx);
    return {seed, 12'h010, idx};
  endfunction : reg_val

  // Expected notes: code 0 interface write, 1 done, 2 violation, 3 emulation, 4 software read,
  // 5 register write, 6 memory address, 7 memory data.
  task automatic push(input logic [2:0] c, input logic [1:0] s, input logic [2:0] z,
                      input logic [31:0] d);
    exp_q.push_back({c, s, z, d});
  endtask : push

  // New random data and far-side latency before each primitive.
  task automatic newseed();
    logic [31:0] v;
    v = xs();
    seed <= v[15:0];
    dly <= v[17:16];
    @(posedge i_clk);
  endtask : newseed

  // Issue one primitive and wait, bounded, for its ending pulse.
  task automatic prim(input logic [15:0] w, input logic cc, input logic [2:0] m,
                      input logic [2:0] r);
    int k;
    k = 0;
    i_prim_valid <= 1'b1;
    i_prim_word <= w;
    i_cond_cat <= cc;
    i_ea_mode <= m;
    i_ea_reg <= r;
    @(posedge i_clk);
    i_prim_valid <= 1'b0;
    do begin
      @(posedge i_clk);
      k++;
    end while (k < 200 && !(o_done === 1'b1 || o_proto_viol === 1'b1 || o_opcode_emul === 1'b1));
  endtask : prim

  task automatic proto(input logic [15:0] w, input logic cc, input logic [2:0] m,
                       input logic [2:0] r);
    newseed();
    push(3'h2, 2'h0, 3'h0, 32'h0);
    prim(w, cc, m, r);
  endtask : proto

  task automatic sw_access(input logic wr, input logic [1:0] a, input logic [31:0] d);
    i_sw_wr <= wr;
    i_sw_rd <= !wr;
    i_sw_addr <= a;
    i_sw_wdata <= d;
    @(posedge i_clk);
    i_sw_wr <= 1'b0;
    i_sw_rd <= 1'b0;
    @(posedge i_clk);
  endtask : sw_access

  task automatic chk(input logic [39:0] got);
    logic [39:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : {40{1'bx}};
    compares++;
    if (got !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk

  // Every result the block shows is matched against the oldest expectation.
  always @(posedge i_clk) begin
    rd_q <= i_sw_rd;
    if (i_rst_n === 1'b1) begin
      if (o_cir_wr === 1'b1 && i_cir_ack === 1'b1) chk({3'h0, o_cir_sel, o_cir_size, o_cir_wdata});
      if (o_reg_wr === 1'b1) chk({3'h5, 1'b0, o_reg_idx, o_reg_wdata});
      if (o_mem_wr === 1'b1 && i_mem_ack === 1'b1) chk({3'h6, 2'h0, o_mem_size, o_mem_addr});
      if (o_mem_wr === 1'b1 && i_mem_ack === 1'b1) chk({3'h7, 5'h0, o_mem_wdata});
      if (o_done === 1'b1) chk({3'h1, 35'h0, o_come_again, o_busy});
      if (o_proto_viol === 1'b1) chk({3'h2, 36'h0, o_busy});
      if (o_opcode_emul === 1'b1) chk({3'h3, 36'h0, o_busy});
      if (rd_q === 1'b1) chk({3'h4, 5'h0, o_sw_rdata});
    end
  end

  task automatic results();
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  // Watchdog well beyond the expected run length.
  initial begin
    #2000000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    // Six-byte stream: one long word, then the trailing word, pointer ends past it.
    sw_access(1'b1, SW_SCAN, 32'h0000_0100);
    newseed();
    push(3'h0, SEL_OPER, SZ_LONG, {16'h0100 ^ seed, 16'h0102 ^ seed});
    push(3'h0, SEL_OPER, SZ_WORD, {16'h0, 16'h0104 ^ seed});
    push(3'h1, 2'h0, 3'h0, 32'h2);
    prim({2'b10, IS_CODE, 8'h06}, 1'b0, MD_DREG, 3'h0);
    push(3'h4, 2'h0, 3'h0, 32'h0000_0106);
    sw_access(1'b0, SW_SCAN, 32'h0);
    // Refused primitives, each ending in a protocol violation.
    proto({2'b00, IS_CODE, 8'h04}, 1'b1, MD_DREG, 3'h0);
    proto({2'b10, IS_CODE, 8'h03}, 1'b0, MD_DREG, 3'h0);
    proto({2'b00, EAA_CODE, EAA_LOW}, 1'b1, MD_IND, 3'h3);
    proto({3'b000, EAT_CODE, CAT_ANY, LEN_LONG}, 1'b1, MD_DREG, 3'h2);
    proto({3'b000, EAT_CODE, CAT_ANY, 8'h03}, 1'b0, MD_DREG, 3'h2);
    proto({3'b001, EAT_CODE, CAT_ANY, LEN_LONG}, 1'b0, MD_EXT, XR_PCD);
    proto({3'b001, EAT_CODE, CAT_ANY, LEN_WORD}, 1'b0, MD_EXT, XR_IMM);
    proto({3'b000, EAT_CODE, CAT_ANY, 8'h03}, 1'b0, MD_EXT, XR_IMM);
    push(3'h4, 2'h0, 3'h0, 32'h0000_0001);
    sw_access(1'b0, SW_STAT, 32'h0);
    push(3'h4, 2'h0, 3'h0, 32'h0);
    sw_access(1'b0, 2'h3, 32'h0);
    // Address evaluation: legal indirect mode, then an illegal data-register mode.
    newseed();
    push(3'h0, SEL_ADDR, SZ_LONG, reg_val(4'hb));
    push(3'h1, 2'h0, 3'h0, 32'h0);
    prim({2'b00, EAA_CODE, EAA_LOW}, 1'b0, MD_IND, 3'h3);
    newseed();
    push(3'h0, SEL_CTRL, SZ_WORD, ABORT_MASK);
    push(3'h3, 2'h0, 3'h0, 32'h0);
    prim({2'b00, EAA_CODE, EAA_LOW}, 1'b0, MD_DREG, 3'h0);
    // Data register against every category: only data alterable, alterable, data and any (the odd codes) accept it.
    for (int c = 0; c < 8; c++) begin
      newseed();
      if (c[0]) begin
        push(3'h0, SEL_OPER, SZ_LONG, reg_val(4'h2));
        push(3'h1, 2'h0, 3'h0, 32'h0);
      end else begin
        push(3'h0, SEL_CTRL, SZ_WORD, ABORT_MASK);
        push(3'h3, 2'h0, 3'h0, 32'h0);
      end
      prim({3'b000, EAT_CODE, 3'(c), LEN_LONG}, 1'b0, MD_DREG, 3'h2);
    end
    // Eight bytes from memory through an address register, then a zero-length move.
    newseed();
    base = reg_val(4'h9);
    push(3'h0, SEL_OPER, SZ_LONG, base ^ {seed, seed});
    push(3'h0, SEL_OPER, SZ_LONG, (base + 32'h4) ^ {seed, seed});
    push(3'h1, 2'h0, 3'h0, 32'h0);
    prim({3'b000, EAT_CODE, CAT_MEM_ALT, 8'h08}, 1'b0, MD_IND, 3'h1);
    newseed();
    push(3'h1, 2'h0, 3'h0, 32'h0);
    prim({3'b000, EAT_CODE, CAT_MEM, 8'h00}, 1'b0, MD_IND, 3'h1);
    // One byte to (SP)+: the pointer steps by two so the stack stays word aligned.
    newseed();
    base = reg_val(4'hf);
    push(3'h5, 2'h1, SP_REG, base + 32'h2);
    push(3'h6, 2'h0, SZ_BYTE, base);
    push(3'h7, 2'h0, 3'h0, {seed, ~seed});
    push(3'h1, 2'h0, 3'h0, 32'h0);
    prim({3'b001, EAT_CODE, CAT_MEM_ALT, LEN_BYTE}, 1'b0, MD_POST, SP_REG);
    // Register direct from the coprocessor: address registers sign-extend, data registers merge.
    newseed();
    push(3'h5, 2'h1, 3'h5, {{24{~seed[7]}}, ~seed[7:0]});
    push(3'h1, 2'h0, 3'h0, 32'h0);
    prim({3'b001, EAT_CODE, CAT_ANY, LEN_BYTE}, 1'b0, MD_AREG, 3'h5);
    newseed();
    base = reg_val(4'h5);
    push(3'h5, 2'h0, 3'h5, {base[31:16], ~seed});
    push(3'h1, 2'h0, 3'h0, 32'h0);
    prim({3'b001, EAT_CODE, CAT_DATA_ALT, LEN_WORD}, 1'b0, MD_DREG, 3'h5);
    // Six-byte immediate from the stream, then a displacement taken from the next word.
    sw_access(1'b1, SW_SCAN, 32'h0000_0200);
    newseed();
    push(3'h0, SEL_OPER, SZ_LONG, {16'h0200 ^ seed, 16'h0202 ^ seed});
    push(3'h0, SEL_OPER, SZ_WORD, {16'h0, 16'h0204 ^ seed});
    push(3'h1, 2'h0, 3'h0, 32'h0);
    prim({3'b000, EAT_CODE, CAT_ANY, 8'h06}, 1'b0, MD_EXT, XR_IMM);
    newseed();
    push(3'h0, SEL_ADDR, SZ_LONG, reg_val(4'hc) + 32'($signed(16'h0206 ^ seed)));
    push(3'h1, 2'h0, 3'h0, 32'h0);
    prim({2'b00, EAA_CODE, EAA_LOW}, 1'b0, MD_DISP, 3'h4);
    push(3'h4, 2'h0, 3'h0, 32'h0000_0208);
    sw_access(1'b0, SW_SCAN, 32'h0);
    repeat (5) @(posedge i_clk);
    if (exp_q.size() != 0) begin
      n_fail++;
      $display("mismatch at %0t: %0d expected results never seen", $time, exp_q.size());
    end
    results();
  end
endmodule : tb
